// ==== gci_pcm_frame_interface.sv ====
// Frame interface for a two-mode voice highway: GCI packets or PCM time slots.
// Assumes frame sync and downstream data are synchronous to i_link_clk, while
// configuration, signaling bits and the upstream word source live on i_clk.
`timescale 1ns/1ps
module gci_pcm_frame_interface
    import gci_pcm_pkg::*;
#(
    parameter int FRAME_LOSS_LIMIT = FRAME_LOSS_CYCLES,
    parameter int SIG_BITS         = SIG_W
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_link_clk,
    input  wire logic                  i_gci_mode,
    input  wire logic                  i_gci_double_clk,
    input  wire logic [SLOT_SEL_W-1:0] i_pcm_slot,
    input  wire int_drive_t            i_int_drive,
    input  wire logic                  i_transmit_data_irq_arm,
    input  wire logic [SIG_BITS-1:0]   i_irq_mask,
    input  wire logic                  i_sig_read,
    input  wire logic                  i_soft_reset,
    input  wire logic [SIG_BITS-1:0]   i_sig_in,
    output logic      [SIG_BITS-1:0]   o_sig_state,
    output logic                       o_irq_pending,
    input  wire logic [WORD_W-1:0]     i_tx_data,
    input  wire logic                  i_tx_valid,
    output logic                       o_tx_ready,
    output logic      [WORD_W-1:0]     o_rx_data,
    output logic                       o_rx_valid,
    output logic                       o_frame_active,
    input  wire logic                  i_frame_sync,
    input  wire logic                  i_downstream_data_in,
    output logic                       o_upstream_data_out,
    output logic                       o_upstream_data_out_oe_n,
    input  wire logic                  i_packet_select_bit0,
    input  wire logic                  i_packet_select_bit1,
    input  wire logic                  i_packet_select_bit2,
    output logic                       o_int_n_out,
    output logic                       o_int_oe_n
);

    if (SIG_BITS < 1 || FRAME_LOSS_LIMIT < 2 || FRAME_LOSS_LIMIT > 65535) begin : g_param_check
        $error("gci_pcm_frame_interface parameters out of range");
    end

    // Picks the bit of the current slot, most significant first within its span.
    function automatic logic pick_bit(input logic [WORD_W-1:0] word,
                                      input logic [4:0]        idx,
                                      input logic              gci);
        logic [4:0] pos;
        pos      = (gci ? GCI_LAST : PCM_LAST) - idx;
        pick_bit = word[pos];
    endfunction : pick_bit
    // ---------------- Link clock domain ----------------
    link_cfg_t   cfg_sys;
    link_cfg_t   cfg_link;
    packet_sel_t sel_pin;
    packet_sel_t sel_link;

    assign cfg_sys = '{gci_mode: i_gci_mode, double_clk: i_gci_double_clk,
                       pcm_slot: i_pcm_slot};
    assign sel_pin = '{bit2: i_packet_select_bit2, bit1: i_packet_select_bit1,
                       bit0: i_packet_select_bit0};

    cdc_sync #(.W($bits(link_cfg_t))) u_cfg_sync (
        .i_clk  (i_link_clk),
        .i_rstn (i_rstn),
        .i_d    (cfg_sys),
        .o_q    (cfg_link)
    );

    cdc_sync #(.W($bits(packet_sel_t))) u_sel_sync (
        .i_clk  (i_link_clk),
        .i_rstn (i_rstn),
        .i_d    (sel_pin),
        .o_q    (sel_link)
    );

    logic              fs_prev_reg;
    logic              fs_start;
    logic              phase_reg;
    logic              dbl;
    logic              tick;
    logic [CNT_W-1:0]  bit_cnt_reg;
    logic              in_window;
    logic [4:0]        idx;
    logic [4:0]        last_idx;
    logic [WORD_W-1:0] tx_word_reg;
    logic [WORD_W-1:0] rx_shift_reg;
    logic [WORD_W-1:0] rx_hold_reg;
    logic [WORD_W-1:0] rx_next;
    logic              rx_tgl_reg;
    logic              frame_tgl_reg;
    logic [WORD_W-1:0] fifo_rdata;
    logic              fifo_rvalid;

    assign fs_start = i_frame_sync && !fs_prev_reg;
    // A 4.096 MHz GCI clock carries each bit for two clock periods.
    assign dbl      = cfg_link.gci_mode && cfg_link.double_clk;
    assign tick     = !dbl || phase_reg;
    assign last_idx = cfg_link.gci_mode ? GCI_LAST : PCM_LAST;
    assign idx      = cfg_link.gci_mode ? bit_cnt_reg[4:0] : {2'b00, bit_cnt_reg[2:0]};

    // The counter parks at 256 so that a fast clock never wraps into a second window.
    always_comb begin
        if (bit_cnt_reg[CNT_W-1]) begin
            in_window = 1'b0;
        end else if (cfg_link.gci_mode) begin
            in_window = (bit_cnt_reg[7:5] == sel_link);
        end else begin
            in_window = (bit_cnt_reg[7:3] == cfg_link.pcm_slot);
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fs_prev_reg <= 1'b0;
        end else begin
            fs_prev_reg <= i_frame_sync;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg <= 1'b0;
        end else if (fs_start || !dbl) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_cnt_reg <= {1'b1, 8'h00};
        end else if (fs_start) begin
            bit_cnt_reg <= CNT_ZERO;
        end else if (tick && !bit_cnt_reg[CNT_W-1]) begin
            bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
        end
    end

    // One upstream word per frame is taken at frame sync; an empty FIFO sends idle ones.
    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_word_reg <= IDLE_WORD;
        end else if (fs_start) begin
            tx_word_reg <= fifo_rvalid ? fifo_rdata : IDLE_WORD;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_upstream_data_out      <= 1'b1;
            o_upstream_data_out_oe_n <= 1'b1;
        end else begin
            o_upstream_data_out      <= in_window ?
                                        pick_bit(tx_word_reg, idx, cfg_link.gci_mode) : 1'b1;
            o_upstream_data_out_oe_n <= !in_window;
        end
    end

    assign rx_next = {rx_shift_reg[WORD_W-2:0], i_downstream_data_in};

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_shift_reg <= '0;
            rx_hold_reg  <= '0;
            rx_tgl_reg   <= 1'b0;
        end else if (in_window && tick) begin
            rx_shift_reg <= rx_next;
            if (idx == last_idx) begin
                rx_hold_reg <= cfg_link.gci_mode ? rx_next : {24'h00_0000, rx_next[7:0]};
                rx_tgl_reg  <= !rx_tgl_reg;
            end
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frame_tgl_reg <= 1'b0;
        end else if (fs_start) begin
            frame_tgl_reg <= !frame_tgl_reg;
        end
    end

    cdc_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_wclk   (i_clk),
        .i_rstn   (i_rstn),
        .i_wdata  (i_tx_data),
        .i_wvalid (i_tx_valid),
        .o_wready (o_tx_ready),
        .i_rclk   (i_link_clk),
        .o_rdata  (fifo_rdata),
        .o_rvalid (fifo_rvalid),
        .i_rready (fs_start)
    );

    // ---------------- System clock domain ----------------
    logic [1:0]          tgl_sys;
    logic [1:0]          tgl_prev_reg;
    logic                rx_event;
    logic                frame_event;
    logic [15:0]         loss_cnt_reg;
    logic [SIG_BITS-1:0] sig_prev_reg;
    logic [SIG_BITS-1:0] sig_changed;
    logic                irq_set;
    logic                irq_clear;
    logic                irq_reg;

    cdc_sync #(.W(2)) u_tgl_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    ({frame_tgl_reg, rx_tgl_reg}),
        .o_q    (tgl_sys)
    );

    cdc_sync #(.W(SIG_BITS)) u_sig_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    (i_sig_in),
        .o_q    (o_sig_state)
    );

    assign rx_event    = tgl_sys[0] ^ tgl_prev_reg[0];
    assign frame_event = tgl_sys[1] ^ tgl_prev_reg[1];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tgl_prev_reg <= 2'h0;
        end else begin
            tgl_prev_reg <= tgl_sys;
        end
    end

    // The held word is stable for a whole frame, far longer than the toggle takes to cross.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_data  <= '0;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= rx_event;
            if (rx_event) begin
                o_rx_data <= rx_hold_reg;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            loss_cnt_reg   <= 16'h0000;
            o_frame_active <= 1'b0;
        end else if (frame_event) begin
            loss_cnt_reg   <= 16'h0000;
            o_frame_active <= 1'b1;
        end else if (loss_cnt_reg == 16'(FRAME_LOSS_LIMIT)) begin
            o_frame_active <= 1'b0;
        end else begin
            loss_cnt_reg <= loss_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sig_prev_reg <= '0;
        end else begin
            sig_prev_reg <= o_sig_state;
        end
    end

    assign sig_changed = (o_sig_state ^ sig_prev_reg) & ~i_irq_mask;
    assign irq_set     = (|sig_changed) ||
                         (i_transmit_data_irq_arm && i_tx_valid && o_tx_ready);
    assign irq_clear   = i_sig_read || i_soft_reset;

    // A new event in the clearing cycle wins, so no change is ever lost.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_reg <= 1'b0;
        end else if (irq_set) begin
            irq_reg <= 1'b1;
        end else if (irq_clear) begin
            irq_reg <= 1'b0;
        end
    end
    assign o_irq_pending = irq_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_int_n_out <= 1'b1;
            o_int_oe_n  <= 1'b1;
        end else if (i_gci_mode) begin
            o_int_n_out <= 1'b1;
            o_int_oe_n  <= 1'b1;
        end else if (i_int_drive == DRV_OPEN_DRAIN) begin
            o_int_n_out <= 1'b0;
            o_int_oe_n  <= !irq_reg;
        end else begin
            o_int_n_out <= !irq_reg;
            o_int_oe_n  <= 1'b0;
        end
    end

    // ---------------- Checks ----------------
    frame_start_a: assert property (
        @(posedge i_link_clk) disable iff (!i_rstn)
        fs_start |=> (bit_cnt_reg == CNT_ZERO))
        else $error("bit counter did not restart at frame sync");
    msb_first_a: assert property (
        @(posedge i_link_clk) disable iff (!i_rstn)
        (cfg_link.gci_mode && in_window && idx == IDX_FIRST && !fs_start)
        |=> (o_upstream_data_out == tx_word_reg[WORD_W-1]) && !o_upstream_data_out_oe_n)
        else $error("first upstream bit of the packet was not the word MSB");
    packet_span_a: assert property (
        @(posedge i_link_clk) disable iff (!i_rstn)
        (cfg_link.gci_mode && !dbl && in_window && idx == IDX_FIRST && !fs_start)
        |-> (in_window && !fs_start) [*8])
        else $error("packet window shorter than expected");
    four_bytes_a: assert property (
        @(posedge i_link_clk) disable iff (!i_rstn)
        (cfg_link.gci_mode && $changed(rx_tgl_reg)) |-> ($past(idx) == GCI_LAST))
        else $error("downstream word closed before the 32nd bit");
    half_rate_a: assert property (
        @(posedge i_link_clk) disable iff (!i_rstn)
        (dbl && tick && !fs_start) ##1 (dbl && !fs_start) |=> $stable(bit_cnt_reg))
        else $error("double-rate GCI clock advanced a bit on consecutive edges");
    pcm_rate_a: assert property (
        @(posedge i_link_clk) disable iff (!i_rstn)
        (!cfg_link.gci_mode && !fs_start && !bit_cnt_reg[CNT_W-1])
        |=> (bit_cnt_reg == $past(bit_cnt_reg) + CNT_ONE))
        else $error("PCM bit counter did not follow the PCM clock");
    sig_irq_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (|sig_changed) |=> irq_reg ##1 (i_gci_mode || (!o_int_n_out && !o_int_oe_n)))
        else $error("unmasked signaling change did not raise the interrupt");
    tx_irq_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_transmit_data_irq_arm && i_tx_valid && o_tx_ready) |=> irq_reg)
        else $error("armed transmit data did not raise the interrupt");
    irq_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (irq_reg && !i_sig_read && !i_soft_reset) |=> irq_reg)
        else $error("interrupt dropped without a read or reset");
    pin_input_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_gci_mode |=> o_int_oe_n)
        else $error("interrupt pin driven while it carries packet select");
    open_drain_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (!i_gci_mode && i_int_drive == DRV_OPEN_DRAIN)
        |=> !o_int_n_out && (o_int_oe_n == !$past(irq_reg)))
        else $error("open-drain interrupt drove high or missed its low");
endmodule : gci_pcm_frame_interface

// ==== gci_pcm_pkg.sv ====
// Shared constants and types for the GCI / PCM frame interface.
// Assumes a 20 MHz system clock and a separate bit clock from the highway controller.
package gci_pcm_pkg;

    localparam int WORD_W         = 32;
    localparam int FIFO_DEPTH     = 4;
    localparam int SIG_W          = 16;
    localparam int CNT_W          = 9;
    localparam int SLOT_SEL_W     = 5;
    localparam int PACKET_BITS    = 32;
    localparam int SLOT_BITS      = 8;

    localparam logic [WORD_W-1:0] IDLE_WORD   = 32'hFFFF_FFFF;
    localparam logic [4:0]        GCI_LAST    = 5'h1F;
    localparam logic [4:0]        PCM_LAST    = 5'h07;
    localparam logic [4:0]        IDX_FIRST   = 5'h00;
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 9'h000;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 9'h001;

    // Frame sync is 8 kHz; loss is declared after two missing frame periods.
    localparam int CLK_HZ            = 20_000_000;
    localparam int CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
    localparam int FRAME_PERIOD_NS   = 125_000;
    localparam int FRAME_LOSS_NS     = 2 * FRAME_PERIOD_NS;
    localparam int FRAME_LOSS_CYCLES = FRAME_LOSS_NS / CLK_PERIOD_NS;

    typedef enum logic {
        DRV_PUSH_PULL  = 1'b0,
        DRV_OPEN_DRAIN = 1'b1
    } int_drive_t;

    typedef struct packed {
        logic                  gci_mode;
        logic                  double_clk;
        logic [SLOT_SEL_W-1:0] pcm_slot;
    } link_cfg_t;

    typedef struct packed {
        logic bit2;
        logic bit1;
        logic bit0;
    } packet_sel_t;

endpackage : gci_pcm_pkg

// ==== cdc_sync.sv ====
// Two-flop level synchroniser, any width.
// Assumes each bit is a level or a slowly changing quasi-static value.
`timescale 1ns/1ps
module cdc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '0;
            o_q      <= '0;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end
endmodule : cdc_sync

// ==== cdc_fifo.sv ====
// Dual-clock FIFO with gray-coded pointers and valid/ready on both sides.
// Assumes both sides share the asynchronous reset; depth is a power of two, at least 4.
`timescale 1ns/1ps
module cdc_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 4
) (
    input  wire logic         i_wclk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic         i_wvalid,
    output logic              o_wready,
    input  wire logic         i_rclk,
    output logic      [W-1:0] o_rdata,
    output logic              o_rvalid,
    input  wire logic         i_rready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("cdc_fifo depth must be a power of two of at least 4");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wbin_reg;
    logic [AW:0]  wgray_reg;
    logic [AW:0]  rbin_reg;
    logic [AW:0]  rgray_reg;
    logic [AW:0]  rgray_w;
    logic [AW:0]  wgray_r;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    cdc_sync #(.W(AW + 1)) u_rptr_sync (
        .i_clk  (i_wclk),
        .i_rstn (i_rstn),
        .i_d    (rgray_reg),
        .o_q    (rgray_w)
    );

    cdc_sync #(.W(AW + 1)) u_wptr_sync (
        .i_clk  (i_rclk),
        .i_rstn (i_rstn),
        .i_d    (wgray_reg),
        .o_q    (wgray_r)
    );

    assign o_wready = (wgray_reg != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign o_rvalid = (rgray_reg != wgray_r);
    assign o_rdata  = mem[rbin_reg[AW-1:0]];

    always_ff @(posedge i_wclk) begin
        if (i_wvalid && o_wready) begin
            mem[wbin_reg[AW-1:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_wclk or negedge i_rstn) begin
        if (!i_rstn) begin
            wbin_reg  <= '0;
            wgray_reg <= '0;
        end else if (i_wvalid && o_wready) begin
            wbin_reg  <= wbin_reg + 1'b1;
            wgray_reg <= to_gray(wbin_reg + 1'b1);
        end
    end

    always_ff @(posedge i_rclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rbin_reg  <= '0;
            rgray_reg <= '0;
        end else if (o_rvalid && i_rready) begin
            rbin_reg  <= rbin_reg + 1'b1;
            rgray_reg <= to_gray(rbin_reg + 1'b1);
        end
    end

    full_hold_a: assert property (
        @(posedge i_wclk) disable iff (!i_rstn)
        (!o_wready) |=> $stable(wbin_reg))
        else $error("write pointer moved while the FIFO was full");

    empty_hold_a: assert property (
        @(posedge i_rclk) disable iff (!i_rstn)
        (!o_rvalid) |=> $stable(rbin_reg))
        else $error("read pointer moved while the FIFO was empty");
endmodule : cdc_fifo

// ==== highway_model.sv ====
// Behavioural highway controller: frame sync, downstream bits, upstream capture.
// Assumes the bench runs the bit clock and calls send_frame for each frame.
`timescale 1ns/1ps
module highway_model (
    input  wire logic i_link_clk,
    input  wire logic i_up,
    input  wire logic i_up_oe_n,
    output logic      o_fs,
    output logic      o_dd
);
    initial begin
        o_fs = 1'b0;
        o_dd = 1'b0;
    end
    // r is the number of bit-clock periods per bit: 1, or 2 for the double-rate clock.
    task automatic send_frame(input logic [31:0] dw, input int p, input int nb, input int r,
                              output logic [31:0] up, output int first, output int n);
        int k;
        int w0;
        up = '0;
        first = -1;
        n = 0;
        w0 = r * p * nb;
        @(negedge i_link_clk);
        o_fs = 1'b1;
        for (k = 0; k < 300 * r; k++) begin
            @(negedge i_link_clk);
            o_fs = 1'b0;
            if (i_up_oe_n === 1'b0) begin
                if (first < 0) first = k;
                if ((k - first) % r == 0) begin
                    up = {up[30:0], i_up};
                    n++;
                end
            end
            // Outside the window the line toggles, so a stale bit never passes for data.
            if (k >= w0 && k < w0 + r * nb) o_dd = dw[nb - 1 - (k - w0) / r];
            else o_dd = ~o_dd;
        end
    endtask : send_frame
endmodule : highway_model

// ==== testbench.sv ====
// Self-checking bench for the frame interface, driving inputs on falling edges.
// Assumes highway_model stands at the link pins and the bit clock runs freely.
`timescale 1ns/1ps
module testbench;
    import gci_pcm_pkg::*;
    logic clk = 0, lclk = 0, rstn = 0, gci = 0, rd = 0, srst = 0, arm = 0, valid = 0;
    logic sel0 = 0, sel1 = 0, sel2 = 0, pin2, pend, tx_ready, rx_valid, fs, dd, up, up_oe_n;
    logic int_out, int_oe_n, fa, fa_seen = 0, dclk = 0;
    logic [15:0] sig_st;
    int_drive_t drv = DRV_PUSH_PULL;
    logic [SLOT_SEL_W-1:0] slot = 5'h03;
    logic [15:0] mask = 16'h0000, sig = 16'h0000;
    logic [31:0] txd = 32'h0000_0000, rx_data, rx_seen, upw;
    int fail_count = 0, n_compared = 0, rx_cnt = 0, first, n, p, c0;
    initial forever #25 clk = ~clk;
    initial forever #40 lclk = ~lclk;
    // The shared pin reads back the driven level, or the select when released.
    assign pin2 = (int_oe_n === 1'b0) ? int_out : sel2;
    always @(posedge clk) if (rx_valid === 1'b1) begin
        rx_seen <= rx_data;
        rx_cnt <= rx_cnt + 1;
    end
    always @(posedge clk) if (fa === 1'b1) fa_seen <= 1'b1;
    gci_pcm_frame_interface #(.FRAME_LOSS_LIMIT(20)) gci_pcm_frame_interface_i (
        .i_clk(clk), .i_rstn(rstn), .i_link_clk(lclk), .i_gci_mode(gci),
        .i_gci_double_clk(dclk), .i_pcm_slot(slot), .i_int_drive(drv),
        .i_transmit_data_irq_arm(arm), .i_irq_mask(mask), .i_sig_read(rd),
        .i_soft_reset(srst), .i_sig_in(sig), .o_sig_state(sig_st), .o_irq_pending(pend),
        .i_tx_data(txd), .i_tx_valid(valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .o_frame_active(fa), .i_frame_sync(fs),
        .i_downstream_data_in(dd), .o_upstream_data_out(up),
        .o_upstream_data_out_oe_n(up_oe_n), .i_packet_select_bit0(sel0),
        .i_packet_select_bit1(sel1), .i_packet_select_bit2(pin2),
        .o_int_n_out(int_out), .o_int_oe_n(int_oe_n));
    highway_model highway_model_i (.i_link_clk(lclk), .i_up(up), .i_up_oe_n(up_oe_n),
        .o_fs(fs), .o_dd(dd));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic put_word(input logic [31:0] w);
        @(negedge clk);
        chk("tx_ready", 1, tx_ready);
        valid = 1'b1;
        txd = w;
        @(negedge clk);
        valid = 1'b0;
    endtask : put_word
    // One frame: packet or slot pk of nb bits, downstream dw, upstream expected eu.
    // r is the number of bit-clock periods per bit.
    task automatic frame(input logic [31:0] dw, input int pk, input int nb, input int r,
                         input logic [31:0] eu);
        c0 = rx_cnt;
        fa_seen = 1'b0;
        highway_model_i.send_frame(dw, pk, nb, r, upw, first, n);
        chk("up_word", eu, upw);
        chk("window_start", r * nb * pk + 1, first);
        chk("bit_count", nb, n);
        chk("rx_count", c0 + 1, rx_cnt);
        chk("rx_word", dw, rx_seen);
        chk("frame_active", 1, fa_seen);
        chk("frame_lost", 0, fa);
    endtask : frame
    task automatic wait_pend(input logic e);
        int i;
        for (i = 0; i < 20 && pend !== e; i++) @(negedge clk);
        chk("irq_pending", e, pend);
    endtask : wait_pend
    initial begin
        #3_000_000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clk);
        chk("up_oe_n_reset", 1, up_oe_n);
        chk("int_reset", 1, int_out);
        chk("frame_active_reset", 0, fa);
        rstn = 1'b1;
        put_word(32'h0000_005A);
        repeat (20) @(negedge clk);
        frame(32'h0000_00C3, 3, 8, 1, 32'h0000_005A);
        $display("pcm slot test done");
        sig[3] = 1'b1;
        wait_pend(1);
        chk("sig_state", sig, sig_st);
        repeat (2) @(negedge clk);
        chk("int_pin", 0, {int_out, int_oe_n});
        repeat (5) @(negedge clk);
        chk("int_held", 1, pend);
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        wait_pend(0);
        mask[5] = 1'b1;
        sig[5] = 1'b1;
        repeat (10) @(negedge clk);
        chk("masked_irq", 0, pend);
        arm = 1'b1;
        drv = DRV_OPEN_DRAIN;
        put_word(32'h1234_5678);
        wait_pend(1);
        repeat (2) @(negedge clk);
        chk("od_low", 0, {int_out, int_oe_n});
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        wait_pend(0);
        repeat (3) @(negedge clk);
        chk("od_release", 1, int_oe_n);
        $display("interrupt test done");
        gci = 1'b1;
        arm = 1'b0;
        for (p = 1; p < 4; p++) put_word(32'hA5C3_0F00 + p);
        @(negedge clk);
        chk("fifo_full", 0, tx_ready);
        sig[3] = 1'b0;
        wait_pend(1);
        repeat (3) @(negedge clk);
        chk("gci_pin_input", 1, int_oe_n);
        for (p = 0; p < 8; p++) begin
            {sel2, sel1, sel0} = p[2:0];
            repeat (10) @(negedge clk);
            frame(32'h3C5A_9600 + p, p, 32, 1, (p == 0) ? 32'h1234_5678 :
                  (p < 4) ? 32'hA5C3_0F00 + p : IDLE_WORD);
        end
        $display("gci packet test done");
        dclk = 1'b1;
        {sel2, sel1, sel0} = 3'h5;
        put_word(32'h0F1E_2D3C);
        repeat (10) @(negedge clk);
        frame(32'h6B2D_E147, 5, 32, 2, 32'h0F1E_2D3C);
        $display("gci double clock test done");
        close_out();
    end
endmodule : testbench
